// File: rtl/module_mgmt_pkg.sv
// Constants, types and timing counts for the module management controller
package module_mgmt_pkg;
    // Clock rate and timing figures
    localparam int CLK_KHZ = 250000;
    localparam int T_INIT_MS = 2000;
    localparam int INIT_CYCLES_DEF = T_INIT_MS * CLK_KHZ;
    localparam int T_RESET_MIN_US = 2;
    localparam int RESET_MIN_CYCLES = (T_RESET_MIN_US * CLK_KHZ + 999) / 1000;
    // 2-wire bus identity; both values arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [7:0] ID_VALUE = 8'h5a;
    // 2-wire byte map
    localparam logic [7:0] BYTE_ID = 8'h00;
    localparam logic [7:0] BYTE_STATUS = 8'h02;
    localparam logic [7:0] BYTE_FLAG_FIRST = 8'h03;
    localparam logic [7:0] BYTE_FLAG_LAST = 8'h05;
    localparam logic [7:0] BYTE_CTRL = 8'h5d;
    localparam logic [7:0] BYTE_MASK_FIRST = 8'h64;
    localparam logic [7:0] BYTE_MASK_LAST = 8'h6a;
    // Field positions and reset values
    localparam int NOT_READY_BIT = 0;
    localparam int CTRL_OVERRIDE_BIT = 0;
    localparam int CTRL_SET_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // APB register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_COND = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_MASKS = 8'h0c;
    // Life-cycle phases
    typedef enum logic [1:0] {
        PH_RESET = 2'b00,
        PH_INIT = 2'b01,
        PH_READY = 2'b10
    } phase_t;
    // 2-wire slave states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_PTR = 3'b010,
        S_WR = 3'b011,
        S_RD = 3'b100,
        S_ACK = 3'b101,
        S_RD_ACK = 3'b110
    } ser_state_t;
endpackage

// File: rtl/module_mgmt_ctrl.sv
// Management controller: init, reset pin, flags, masks, interrupt pin and 2-wire slave
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
module module_mgmt_ctrl #(
    parameter int INIT_CYCLES = module_mgmt_pkg::INIT_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic moduleResetN,
    input wire logic moduleSelectN,
    input wire logic lowPowerPin,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic irqOutN,
    output logic lowPowerState,
    output logic moduleReady
);
    // Whole state of the block
    typedef struct packed {
        logic [1:0] rstSync;
        logic [1:0] selSync;
        logic [1:0] lpSync;
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic sclPrev;
        logic sdaPrev;
        module_mgmt_pkg::phase_t phase;
        logic [9:0] lowCnt;
        logic [31:0] initCnt;
        logic dataNotReady;
        logic readyEvt;
        logic [2:0][7:0] cond;
        logic [2:0][7:0] flags;
        logic [6:0][7:0] masks;
        logic [6:0][7:0] maskShadow;
        logic [7:0] ctrl;
        logic [7:0] ctrlShadow;
        module_mgmt_pkg::ser_state_t ser;
        module_mgmt_pkg::ser_state_t ackNext;
        logic [2:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic ackOn;
        logic nack;
        logic [3:0] readHit;
        logic pendCommit;
        logic sdaOe;
        logic irqOutN;
        logic lowPowerState;
        logic moduleReady;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;
    state_t st;
    state_t next_st;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic resetHit;
    logic commitNow;
    logic serActive;
    logic [7:0] rxByte;
    // Byte seen by the host at a 2-wire address
    function automatic logic [7:0] readByte(input state_t s, input logic [7:0] a);
        logic [7:0] value;
        value = 8'h00;
        if (a == module_mgmt_pkg::BYTE_ID) begin
            value = module_mgmt_pkg::ID_VALUE;
        end else if (a == module_mgmt_pkg::BYTE_STATUS) begin
            value[module_mgmt_pkg::NOT_READY_BIT] = s.dataNotReady;
        end else if (a >= module_mgmt_pkg::BYTE_FLAG_FIRST && a <= module_mgmt_pkg::BYTE_FLAG_LAST) begin
            value = s.flags[2'(a - module_mgmt_pkg::BYTE_FLAG_FIRST)];
        end else if (a == module_mgmt_pkg::BYTE_CTRL) begin
            value = s.ctrl;
        end else if (a >= module_mgmt_pkg::BYTE_MASK_FIRST && a <= module_mgmt_pkg::BYTE_MASK_LAST) begin
            value = s.masks[3'(a - module_mgmt_pkg::BYTE_MASK_FIRST)];
        end
        return value;
    endfunction
    // Edge and condition detection on the synchronised bus lines
    assign sclRise = st.sclSync[1] & ~st.sclPrev;
    assign sclFall = ~st.sclSync[1] & st.sclPrev;
    assign startCond = st.sclSync[1] & st.sclPrev & st.sdaPrev & ~st.sdaSync[1];
    assign stopCond = st.sclSync[1] & st.sclPrev & ~st.sdaPrev & st.sdaSync[1];
    assign resetHit = ~st.rstSync[1] && st.lowCnt == 10'(module_mgmt_pkg::RESET_MIN_CYCLES);
    assign commitNow = st.pendCommit & sclFall;
    assign serActive = ~st.selSync[1] && st.phase != module_mgmt_pkg::PH_RESET;
    assign rxByte = {st.shift[6:0], st.sdaSync[1]};
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.rstSync = {st.rstSync[0], moduleResetN};
        next_st.selSync = {st.selSync[0], moduleSelectN};
        next_st.lpSync = {st.lpSync[0], lowPowerPin};
        next_st.sclSync = {st.sclSync[0], sclIn};
        next_st.sdaSync = {st.sdaSync[0], sdaIn};
        next_st.sclPrev = st.sclSync[1];
        next_st.sdaPrev = st.sdaSync[1];
        // Low time of the reset pin
        if (st.rstSync[1]) begin
            next_st.lowCnt = 10'h0;
        end else if (st.lowCnt != 10'(module_mgmt_pkg::RESET_MIN_CYCLES)) begin
            next_st.lowCnt = st.lowCnt + 10'h1;
        end
        // Committed effects of the last transaction, then new events (set wins)
        if (commitNow) begin
            next_st.masks = st.maskShadow;
            next_st.ctrl = st.ctrlShadow;
            next_st.pendCommit = 1'b0;
            next_st.readHit = 4'h0;
            next_st.readyEvt = st.readyEvt & ~st.readHit[0];
            for (int i = 0; i < 3; i++) begin
                next_st.flags[i] = st.readHit[i + 1] ? 8'h00 : st.flags[i];
            end
        end
        if (st.phase != module_mgmt_pkg::PH_RESET) begin
            next_st.flags = next_st.flags | st.cond;
        end
        // Life-cycle phases
        case (st.phase)
            module_mgmt_pkg::PH_RESET: begin
                if (st.rstSync[1]) begin
                    next_st.phase = module_mgmt_pkg::PH_INIT;
                    next_st.initCnt = 32'h0;
                end
            end
            module_mgmt_pkg::PH_INIT: begin
                next_st.initCnt = st.initCnt + 32'h1;
                if (st.initCnt == INIT_CYCLES - 1) begin
                    next_st.phase = module_mgmt_pkg::PH_READY;
                    next_st.dataNotReady = 1'b0;
                    next_st.readyEvt = 1'b1;
                end
            end
            default: begin
            end
        endcase
        // 2-wire slave
        if (!serActive) begin
            next_st.ser = module_mgmt_pkg::S_IDLE;
            next_st.sdaOe = 1'b0;
            next_st.ackOn = 1'b0;
        end else if (startCond) begin
            next_st.ser = module_mgmt_pkg::S_ADDR;
            next_st.bitCnt = 3'h0;
            next_st.sdaOe = 1'b0;
            next_st.ackOn = 1'b0;
        end else if (stopCond) begin
            next_st.ser = module_mgmt_pkg::S_IDLE;
            next_st.sdaOe = 1'b0;
            next_st.pendCommit = 1'b1;
        end else begin
            case (st.ser)
                module_mgmt_pkg::S_ADDR, module_mgmt_pkg::S_PTR, module_mgmt_pkg::S_WR: begin
                    if (sclRise) begin
                        next_st.shift = rxByte;
                        next_st.bitCnt = st.bitCnt + 3'h1;
                        if (st.bitCnt == 3'h7) begin
                            next_st.ser = module_mgmt_pkg::S_ACK;
                            next_st.ackOn = 1'b0;
                            if (st.ser == module_mgmt_pkg::S_ADDR) begin
                                if (rxByte[7:1] != module_mgmt_pkg::DEV_ADDR) begin
                                    next_st.ser = module_mgmt_pkg::S_IDLE;
                                end
                                next_st.ackNext = rxByte[0] ? module_mgmt_pkg::S_RD : module_mgmt_pkg::S_PTR;
                            end else if (st.ser == module_mgmt_pkg::S_PTR) begin
                                next_st.ptr = rxByte;
                                next_st.ackNext = module_mgmt_pkg::S_WR;
                            end else begin
                                next_st.ptr = st.ptr + 8'h1;
                                next_st.ackNext = module_mgmt_pkg::S_WR;
                                if (st.ptr == module_mgmt_pkg::BYTE_CTRL) begin
                                    next_st.ctrlShadow = rxByte;
                                end else if (st.ptr >= module_mgmt_pkg::BYTE_MASK_FIRST &&
                                             st.ptr <= module_mgmt_pkg::BYTE_MASK_LAST) begin
                                    next_st.maskShadow[3'(st.ptr - module_mgmt_pkg::BYTE_MASK_FIRST)] = rxByte;
                                end
                            end
                        end
                    end
                end
                module_mgmt_pkg::S_ACK: begin
                    if (sclFall && !st.ackOn) begin
                        next_st.ackOn = 1'b1;
                        next_st.sdaOe = 1'b1;
                    end else if (sclFall) begin
                        next_st.ackOn = 1'b0;
                        next_st.sdaOe = 1'b0;
                        next_st.bitCnt = 3'h0;
                        next_st.ser = st.ackNext;
                        if (st.ackNext == module_mgmt_pkg::S_RD) begin
                            next_st.shift = readByte(st, st.ptr);
                            next_st.sdaOe = ~next_st.shift[7];
                        end
                    end
                end
                module_mgmt_pkg::S_RD: begin
                    if (sclRise) begin
                        next_st.bitCnt = st.bitCnt + 3'h1;
                        if (st.bitCnt == 3'h7) begin
                            next_st.ser = module_mgmt_pkg::S_RD_ACK;
                            next_st.ackOn = 1'b0;
                            next_st.ptr = st.ptr + 8'h1;
                            if (st.ptr >= module_mgmt_pkg::BYTE_STATUS && st.ptr <= module_mgmt_pkg::BYTE_FLAG_LAST) begin
                                next_st.readHit[2'(st.ptr - module_mgmt_pkg::BYTE_STATUS)] = 1'b1;
                            end
                        end
                    end else if (sclFall) begin
                        next_st.shift = {st.shift[6:0], 1'b0};
                        next_st.sdaOe = ~st.shift[6];
                    end
                end
                module_mgmt_pkg::S_RD_ACK: begin
                    if (sclFall && !st.ackOn) begin
                        next_st.sdaOe = 1'b0;
                        next_st.ackOn = 1'b1;
                    end else if (sclRise) begin
                        next_st.nack = st.sdaSync[1];
                    end else if (sclFall) begin
                        next_st.ackOn = 1'b0;
                        next_st.bitCnt = 3'h0;
                        if (st.nack) begin
                            next_st.ser = module_mgmt_pkg::S_IDLE;
                        end else begin
                            next_st.ser = module_mgmt_pkg::S_RD;
                            next_st.shift = readByte(st, st.ptr);
                            next_st.sdaOe = ~next_st.shift[7];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // A recognised pin reset restarts the module from scratch
        if (resetHit) begin
            next_st.phase = module_mgmt_pkg::PH_RESET;
            next_st.dataNotReady = 1'b1;
            next_st.readyEvt = 1'b0;
            next_st.flags = '0;
            next_st.masks = {7{module_mgmt_pkg::MASK_RESET}};
            next_st.maskShadow = {7{module_mgmt_pkg::MASK_RESET}};
            next_st.ctrl = module_mgmt_pkg::CTRL_RESET;
            next_st.ctrlShadow = module_mgmt_pkg::CTRL_RESET;
            next_st.pendCommit = 1'b0;
            next_st.readHit = 4'h0;
        end
        // Pins derived from state
        next_st.irqOutN = ~(st.readyEvt | (|(st.flags & ~st.masks[2:0])));
        next_st.lowPowerState = st.lpSync[1] | st.ctrl[module_mgmt_pkg::CTRL_OVERRIDE_BIT] |
                                st.ctrl[module_mgmt_pkg::CTRL_SET_BIT];
        next_st.moduleReady = st.phase == module_mgmt_pkg::PH_READY;
        // APB slave: answer in the first access cycle
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0;
        if (psel && !penable) begin
            next_st.pready = 1'b1;
            if (paddr == module_mgmt_pkg::ADDR_STATUS) begin
                next_st.prdata = {26'h0, st.lowPowerState, ~st.irqOutN, st.phase, st.readyEvt, st.dataNotReady};
            end else if (paddr == module_mgmt_pkg::ADDR_COND) begin
                next_st.prdata = {8'h00, st.cond};
            end else if (paddr == module_mgmt_pkg::ADDR_FLAGS) begin
                next_st.prdata = {8'h00, st.flags};
            end else if (paddr == module_mgmt_pkg::ADDR_MASKS) begin
                next_st.prdata = st.masks[3:0];
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
        if (psel && penable && st.pready && pwrite && paddr == module_mgmt_pkg::ADDR_COND) begin
            next_st.cond = pwdata[23:0];
        end
    end
    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.rstSync <= 2'h3;
            st.selSync <= 2'h3;
            st.sclSync <= 2'h3;
            st.sdaSync <= 2'h3;
            st.sclPrev <= 1'b1;
            st.sdaPrev <= 1'b1;
            st.phase <= module_mgmt_pkg::PH_INIT;
            st.dataNotReady <= 1'b1;
            st.irqOutN <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    // Outputs straight from the state register; sdaOut tied low
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign sdaOut = 1'b0;
    assign sdaOe = st.sdaOe;
    assign irqOutN = st.irqOutN;
    assign lowPowerState = st.lowPowerState;
    assign moduleReady = st.moduleReady;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence initEnd;
        st.phase == module_mgmt_pkg::PH_INIT && st.initCnt == INIT_CYCLES - 1;
    endsequence
    sequence readyThenIrq;
        (st.phase == module_mgmt_pkg::PH_READY && !st.dataNotReady) ##1 !irqOutN;
    endsequence
    init_bound_a: assert property (st.phase == module_mgmt_pkg::PH_INIT |-> st.initCnt < INIT_CYCLES)
        else $error("Init count passed its limit");
    ready_irq_a: assert property (initEnd and !resetHit |=> readyThenIrq)
        else $error("Ready event did not raise interrupt");
    reset_width_a: assert property ($rose(st.phase == module_mgmt_pkg::PH_RESET) |->
                                    $past(st.lowCnt) == 10'(module_mgmt_pkg::RESET_MIN_CYCLES))
        else $error("Reset taken on short pulse");
    flag_latch_a: assert property (st.phase != module_mgmt_pkg::PH_RESET && !resetHit |=>
                                   (st.flags & $past(st.cond)) == $past(st.cond))
        else $error("Condition did not set its flag");
    irq_assert_a: assert property ((|(st.flags & ~st.masks[2:0])) |=> !irqOutN)
        else $error("Unmasked flag left interrupt high");
    irq_release_a: assert property (!st.readyEvt && (st.flags & ~st.masks[2:0]) == '0 |=> irqOutN)
        else $error("Interrupt held with no source");
    lp_entry_a: assert property (st.lpSync[1] ##1 st.lpSync[1] |-> lowPowerState)
        else $error("Low power not entered");
    pdown_exit_a: assert property (st.ctrl == 8'h00 && !st.lpSync[1] |=> !lowPowerState)
        else $error("Low power held after bits cleared");
    deselect_quiet_a: assert property (st.selSync[1] |=> !sdaOe ##1 !sdaOe)
        else $error("Data line driven while deselected");
    mask_commit_a: assert property ($changed(st.masks) |-> $past(commitNow) || $past(resetHit))
        else $error("Mask changed outside commit edge");
    read_clear_a: assert property ($fell(st.readyEvt) |-> $past(commitNow) || $past(resetHit))
        else $error("Read clear outside commit edge");
endmodule

// File: dv/host_link_model.sv
// Host-side 2-wire bus master model driving an open-drain data wire
`timescale 1ns/10ps
module host_link_model (
    input wire logic sdaOe,
    output logic sclLine,
    output logic sdaLine
);
    logic hostLow = 1'b0;
    // Pulled-up wire: low while either side drives it
    assign sdaLine = (hostLow || sdaOe) ? 1'b0 : 1'b1;
    // Clock stands high between frames
    initial sclLine = 1'b1;
    // One bit slot at 125 ns; data changes only while the clock is low
    task automatic slot(input logic b, output logic s);
        sclLine = 1'b0;
        #31.25 hostLow = ~b;
        #31.25 sclLine = 1'b1;
        #62.5 s = sdaLine;
    endtask
    task automatic startBit();
        sclLine = 1'b0;
        #31.25 hostLow = 1'b0;
        #31.25 sclLine = 1'b1;
        #62.5 hostLow = 1'b1;
        #62.5;
    endtask
    // Stop, then one clock fall that commits the transaction
    task automatic stopBit();
        sclLine = 1'b0;
        #31.25 hostLow = 1'b1;
        #31.25 sclLine = 1'b1;
        #62.5 hostLow = 1'b0;
        #62.5 sclLine = 1'b0;
        #62.5 sclLine = 1'b1;
        #62.5;
    endtask
    task automatic sendByte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(v[i], s);
        slot(1'b1, s);
        ack = ~s;
    endtask
    task automatic regWrite(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        startBit();
        sendByte({module_mgmt_pkg::DEV_ADDR, 1'b0}, a0);
        sendByte(p, a1);
        sendByte(d, a2);
        stopBit();
        ok = a0 & a1 & a2;
    endtask
    // Single-byte read ending in a NACK; also how flags are fetched after an interrupt
    task automatic regRead(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic a0, a1, a2, s;
        startBit();
        sendByte({module_mgmt_pkg::DEV_ADDR, 1'b0}, a0);
        sendByte(p, a1);
        startBit();
        sendByte({module_mgmt_pkg::DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, s);
            d[i] = s;
        end
        slot(1'b1, s);
        stopBit();
        ok = a0 & a1 & a2;
    endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the module management controller
`timescale 1ns/10ps
module testbench;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} apb_row_t;
    localparam int INIT = 200;
    logic clock, rstn, psel, penable, pwrite, moduleResetN, moduleSelectN, lowPowerPin, er, ok;
    logic pready, pslverr, sclLine, sdaLine, sdaOe, irqOutN, lowPowerState, moduleReady;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, rd;
    int failCount = 0;
    int numChecks = 0;
    // Register accesses: read-only places ignore writes, unmapped ones refuse
    apb_row_t rows[12] = '{
        '{1'b0, 8'h00, 32'h0, 32'h1a, 1'b0},
        '{1'b1, 8'h00, 32'hffffffff, 32'h0, 1'b0},
        '{1'b1, 8'h08, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h0c, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h40, 32'h1, 32'h0, 1'b1},
        '{1'b1, 8'h04, 32'h00020000, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h00020000, 1'b0},
        '{1'b1, 8'h04, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h00020000, 1'b0}
    };
    module_mgmt_ctrl #(.INIT_CYCLES(INIT)) uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .moduleResetN(moduleResetN), .moduleSelectN(moduleSelectN), .lowPowerPin(lowPowerPin),
        .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .irqOutN(irqOutN),
        .lowPowerState(lowPowerState), .moduleReady(moduleReady));
    host_link_model link (.sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));
    task automatic checkBit(input string s, input logic x, input logic y);
        numChecks++;
        if (y !== x) begin
            failCount++;
            $display("wrong value %s expected %b seen %b", s, x, y);
        end
    endtask
    task automatic checkWord(input string s, input logic [31:0] x, input logic [31:0] y);
        numChecks++;
        if (y !== x) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", s, x, y);
        end
    endtask
    // APB transfer: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? irqOutN : (k == 1 ? lowPowerState : moduleReady);
    endfunction
    // Bounded wait for an output level
    task automatic waitSig(input int k, input logic lvl);
        for (int n = 0; n < 1000 && pick(k) !== lvl; n++) @(posedge clock);
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Watchdog well beyond the expected run time
    initial begin
        #400000;
        failCount++;
        finishTest();
    end
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        moduleResetN = 1'b1;
        moduleSelectN = 1'b0;
        lowPowerPin = 1'b0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        checkBit("irqOutN", 1'b1, irqOutN);
        checkBit("moduleReady", 1'b0, moduleReady);
        waitSig(2, 1'b1);
        checkBit("moduleReady", 1'b1, moduleReady);
        waitSig(0, 1'b0);
        checkBit("irqOutN", 1'b0, irqOutN);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
            checkBit("pslverr", rows[i].e, er);
            if (!rows[i].wr) checkWord("prdata", rows[i].q, rd);
        end
        // Identity, last flag and not-ready bytes; reading the flag and status bytes releases the interrupt
        link.regRead(module_mgmt_pkg::BYTE_ID, b, ok);
        checkBit("ack", 1'b1, ok);
        checkWord("id", {24'h0, module_mgmt_pkg::ID_VALUE}, {24'h0, b});
        link.regRead(module_mgmt_pkg::BYTE_FLAG_LAST, b, ok);
        checkWord("flagByte", 32'h2, {24'h0, b});
        link.regRead(module_mgmt_pkg::BYTE_STATUS, b, ok);
        checkBit("notReady", 1'b0, b[0]);
        waitSig(0, 1'b1);
        checkBit("irqOutN", 1'b1, irqOutN);
        // Loss-of-signal flag: latched, masked, unmasked, cleared by read
        apb(1'b1, module_mgmt_pkg::ADDR_COND, 32'h1, rd, er);
        waitSig(0, 1'b0);
        checkBit("irqOutN", 1'b0, irqOutN);
        apb(1'b1, module_mgmt_pkg::ADDR_COND, 32'h0, rd, er);
        apb(1'b0, module_mgmt_pkg::ADDR_FLAGS, 32'h0, rd, er);
        checkWord("flags", 32'h1, rd);
        link.regWrite(module_mgmt_pkg::BYTE_MASK_FIRST, 8'h01, ok);
        waitSig(0, 1'b1);
        checkBit("irqOutN", 1'b1, irqOutN);
        apb(1'b0, module_mgmt_pkg::ADDR_MASKS, 32'h0, rd, er);
        checkWord("masks", 32'h1, rd);
        link.regWrite(module_mgmt_pkg::BYTE_MASK_LAST, 8'h5c, ok);
        link.regRead(module_mgmt_pkg::BYTE_MASK_LAST, b, ok);
        checkWord("lastMask", 32'h5c, {24'h0, b});
        link.regWrite(module_mgmt_pkg::BYTE_MASK_FIRST, 8'h00, ok);
        waitSig(0, 1'b0);
        checkBit("irqOutN", 1'b0, irqOutN);
        link.regRead(module_mgmt_pkg::BYTE_FLAG_FIRST, b, ok);
        checkWord("flagByte", 32'h1, {24'h0, b});
        waitSig(0, 1'b1);
        checkBit("irqOutN", 1'b1, irqOutN);
        // Low-power pin, then each power-down bit set and cleared
        @(posedge clock);
        lowPowerPin <= 1'b1;
        waitSig(1, 1'b1);
        checkBit("lowPowerState", 1'b1, lowPowerState);
        lowPowerPin <= 1'b0;
        waitSig(1, 1'b0);
        for (int i = 1; i < 3; i++) begin
            link.regWrite(module_mgmt_pkg::BYTE_CTRL, 8'(i), ok);
            waitSig(1, 1'b1);
            checkBit("lowPowerState", 1'b1, lowPowerState);
            link.regWrite(module_mgmt_pkg::BYTE_CTRL, 8'h00, ok);
            waitSig(1, 1'b0);
            checkBit("lowPowerState", 1'b0, lowPowerState);
            checkBit("moduleReady", 1'b1, moduleReady);
        end
        // Deselected module ignores the bus; reselected it answers again
        @(posedge clock);
        moduleSelectN <= 1'b1;
        repeat (10) @(posedge clock);
        link.regRead(module_mgmt_pkg::BYTE_ID, b, ok);
        checkBit("ack", 1'b0, ok);
        @(posedge clock);
        moduleSelectN <= 1'b0;
        repeat (10) @(posedge clock);
        link.regRead(module_mgmt_pkg::BYTE_ID, b, ok);
        checkBit("ack", 1'b1, ok);
        // Short reset pulse ignored, long one restarts initialisation
        for (int w = 100; w <= 600; w += 500) begin
            @(posedge clock);
            moduleResetN <= 1'b0;
            repeat (w) @(posedge clock);
            moduleResetN <= 1'b1;
            repeat (8) @(posedge clock);
            checkBit("moduleReady", w < 500, moduleReady);
        end
        waitSig(2, 1'b1);
        checkBit("moduleReady", 1'b1, moduleReady);
        waitSig(0, 1'b0);
        checkBit("irqOutN", 1'b0, irqOutN);
        finishTest();
    end
endmodule
